// ### bench/psi_host_model.sv
// Host interrupt input that counts requests
`timescale 1ns/10ps
`default_nettype none
module psi_host_model (
    input  wire logic  i_ref_clk,
    input  wire logic  i_rst,
    input  wire logic  i_irq,
    output logic [7:0] o_irq_rises
);
    logic irq_d_reg;
    // Edge-sensing host: a level held high across events counts once
    always_ff @(posedge i_ref_clk) begin
        irq_d_reg <= i_irq;
        o_irq_rises <= i_rst ? 8'h00 : o_irq_rises + {7'h0, i_irq & ~irq_d_reg};
    end
endmodule : psi_host_model
`default_nettype wire

// ### bench/psi_monitor.sv
// Concurrent checks on the indicator and interrupt block ports
`timescale 1ns/10ps
`default_nettype none
module psi_monitor #(
    parameter int unsigned P_SD_QUAL_CYC = 32
) (
    input wire logic                  i_ref_clk,
    input wire logic                  i_rst,
    input wire logic                  i_hsel,
    input wire logic [31:0]           i_haddr,
    input wire logic [1:0]            i_htrans,
    input wire logic                  i_hwrite,
    input wire logic [31:0]           i_hwdata,
    input wire logic                  i_hready,
    input wire logic                  i_rx_active,
    input wire logic                  i_tx_active,
    input wire logic                  i_full_duplex,
    input wire logic [1:0]            i_speed,
    input wire psi_pkg::psi_link_in_s i_link,
    input wire psi_pkg::psi_led_s     o_led,
    input wire logic                  o_irq
);
    logic        wr_reg;
    logic        en_reg;
    logic [7:0]  wa_reg;
    logic [31:0] sd_run_reg;
    wire wr_take = i_hsel & i_htrans[1] & i_hready & i_hwrite;
    wire gig_ok = i_link.train_done & i_link.an_complete & i_link.gig_link_valid & i_link.remote_rx_ok;
    wire [2:0] spd = {o_led.speed_ten_indicator, o_led.speed_hundred_indicator, o_led.speed_gigabit_indicator};
    wire lnk = o_led.good_link_indicator;
    // Shadow of the enable bit, so the interrupt gate can be judged from the bus alone
    always_ff @(posedge i_ref_clk) begin
        wr_reg <= ~i_rst & wr_take;
        wa_reg <= i_haddr[7:0];
        en_reg <= i_rst ? 1'b0 : ((wr_reg && wa_reg == 8'h00) ? i_hwdata[0] : en_reg);
        sd_run_reg <= (i_rst || !i_link.signal_detect) ? 32'h0 : sd_run_reg + 32'h1;
    end
    default clocking dcb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    AST_RX_LED: assert property (!$past(i_rst) |-> o_led.receive_activity_indicator == $past(i_rx_active))
        else $error("receive indicator wrong");
    AST_TX_LED: assert property (!$past(i_rst) |-> o_led.transmit_activity_indicator == $past(i_tx_active))
        else $error("transmit indicator wrong");
    AST_ACT_LED: assert property (!$past(i_rst) |->
        o_led.combined_activity_indicator == ($past(i_rx_active) || $past(i_tx_active)))
        else $error("combined activity wrong");
    AST_COL_LED: assert property (!$past(i_rst) |-> o_led.collision_indicator ==
        ($past(i_rx_active) && $past(i_tx_active) && !$past(i_full_duplex)))
        else $error("collision indicator wrong");
    AST_DPX_LED: assert property (!$past(i_rst) |-> o_led.full_duplex_indicator == $past(i_full_duplex))
        else $error("duplex indicator wrong");
    AST_SPD_GATE: assert property (spd != 3'h0 |-> lnk && $onehot(spd))
        else $error("speed indicator without link or not unique");
    AST_SD_DROP: assert property (i_speed == 2'h1 && $past(i_speed) == 2'h1 && !i_link.signal_detect
        |=> !lnk)
        else $error("link held after signal detect fell");
    AST_SD_QUAL: assert property ($rose(lnk) && i_speed == 2'h1 && $past(i_speed) == 2'h1
        && $past(i_speed, 2) == 2'h1 |-> sd_run_reg >= P_SD_QUAL_CYC)
        else $error("link rose before qualification");
    AST_GIG_LINK: assert property (lnk && i_speed == 2'h2 && $past(i_speed) == 2'h2
        && $past(i_speed, 2) == 2'h2 |-> $past(gig_ok))
        else $error("gigabit link without all conditions");
    // The pin is registered from the stored enable, so it lags an enable write by one edge
    AST_IRQ_GATE: assert property (!$past(en_reg) |-> !o_irq)
        else $error("interrupt while disabled");
    AST_IRQ_HOLD: assert property ($fell(o_irq) && !$past(i_rst) |-> $past(wr_reg) || $past(wr_reg, 2))
        else $error("interrupt dropped without a write");
    AST_IRQ_CAUSE: assert property ($rose(o_irq) && !$past(i_rst, 2) |-> $past(wr_reg) || $past(wr_reg, 2)
        || $past(i_full_duplex) != $past(i_full_duplex, 2) || $past(i_speed) != $past(i_speed, 2)
        || lnk != $past(lnk) || $past(lnk) != $past(lnk, 2))
        else $error("interrupt without a status change");
    cover property ($rose(o_irq));
    cover property ($rose(o_led.speed_hundred_indicator));
    cover property (o_led.collision_indicator);
endmodule : psi_monitor
bind psi_top psi_monitor #(.P_SD_QUAL_CYC(P_SD_QUAL_CYC)) u_mon (.i_ref_clk, .i_rst, .i_hsel, .i_haddr,
    .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .i_rx_active, .i_tx_active, .i_full_duplex, .i_speed,
    .i_link, .o_led, .o_irq);
`default_nettype wire

// ### bench/tb_top.sv
// Register and indicator tests of the status indicator block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int unsigned QUAL = 32;
    logic                  clk, rst, hsel, hwrite, rx, tx, fdx, hready, hresp, irq;
    logic [31:0]           haddr, hwdata, hrdata;
    logic [1:0]            htrans, speed;
    logic [7:0]            rises;
    psi_pkg::psi_link_in_s lnk;
    psi_pkg::psi_led_s     led;
    int error_cnt = 0;
    int total_checks = 0;
    psi_top #(.P_NLP_GAP_CYC(64), .P_SD_QUAL_CYC(QUAL)) DUT (.i_ref_clk(clk), .i_rst(rst), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_rx_active(rx),
        .i_tx_active(tx), .i_full_duplex(fdx), .i_speed(speed), .i_link(lnk), .o_led(led), .o_irq(irq));
    psi_host_model u_host (.i_ref_clk(clk), .i_rst(rst), .i_irq(irq), .o_irq_rises(rises));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_up;
        chk(32'h0, 32'h1);
        end_of_test;
    endtask : give_up
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // Samples ready at the edge, before that edge's updates land
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) give_up;
            @(posedge clk);
        end
    endtask : wait_rdy
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        q = hrdata;
        chk({31'h0, hresp}, 32'h0);
        #1;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rd
    task automatic led_is(input logic [8:0] e);
        chk({23'h0, led}, {23'h0, e});
    endtask : led_is
    // Mask and enable act through stored state, so the pin settles one edge after a write ends
    task automatic irq_is(input logic e);
        cyc(1);
        chk({31'h0, irq}, {31'h0, e});
    endtask : irq_is
    task automatic act(input logic r, input logic t, input logic f, input logic [8:0] e);
        @(posedge clk);
        rx <= r;
        tx <= t;
        fdx <= f;
        cyc(2);
        led_is(e);
    endtask : act
    task automatic wait_link(input int lim);
        int n;
        n = 0;
        while (led.good_link_indicator !== 1'b1) begin
            n++;
            if (n > lim) give_up;
            cyc(1);
        end
    endtask : wait_link
    task automatic pulse_nlp;
        @(posedge clk);
        lnk.nlp_pulse <= 1'b1;
        @(posedge clk);
        lnk.nlp_pulse <= 1'b0;
    endtask : pulse_nlp
    initial begin
        repeat (100000) @(posedge clk);
        give_up;
    end
    initial begin
        {rst, hsel, hwrite, rx, tx, fdx, haddr, hwdata, htrans, speed, lnk} = '0;
        rst = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        cyc(2);
        rd(8'h00, 32'h0);
        rd(8'h08, 32'h7);
        rd(8'h04, 32'h0);
        wr(8'h0c, 32'hff);
        rd(8'h0c, 32'h0);
        rd(8'h10, 32'h0);
        act(1'b1, 1'b0, 1'b0, 9'h108);
        act(1'b0, 1'b1, 1'b0, 9'h088);
        act(1'b1, 1'b1, 1'b0, 9'h198);
        act(1'b1, 1'b1, 1'b1, 9'h1a8);
        act(1'b0, 1'b0, 1'b1, 9'h020);
        irq_is(1'b0);
        rd(8'h04, 32'h4);
        wr(8'h00, 32'h1);
        irq_is(1'b1);
        wr(8'h08, 32'h0);
        irq_is(1'b0);
        wr(8'h08, 32'h7);
        irq_is(1'b1);
        wr(8'h04, 32'h4);
        irq_is(1'b0);
        rd(8'h04, 32'h0);
        @(posedge clk);
        speed <= 2'h1;
        lnk.signal_detect <= 1'b1;
        cyc(QUAL - 8);
        led_is(9'h020);
        irq_is(1'b1);
        wait_link(20);
        led_is(9'h062);
        @(posedge clk);
        lnk.signal_detect <= 1'b0;
        cyc(1);
        led_is(9'h020);
        rd(8'h04, 32'h3);
        wr(8'h04, 32'h7);
        irq_is(1'b0);
        chk({24'h0, rises}, 32'h3);
        @(posedge clk);
        speed <= 2'h2;
        lnk.train_done <= 1'b1;
        lnk.an_complete <= 1'b1;
        lnk.gig_link_valid <= 1'b1;
        cyc(4);
        led_is(9'h020);
        @(posedge clk);
        lnk.remote_rx_ok <= 1'b1;
        cyc(3);
        led_is(9'h061);
        @(posedge clk);
        speed <= 2'h3;
        cyc(3);
        led_is(9'h020);
        irq_is(1'b1);
        wr(8'h00, 32'h0);
        irq_is(1'b0);
        wr(8'h00, 32'h1);
        irq_is(1'b1);
        @(posedge clk);
        speed <= 2'h0;
        lnk <= '0;
        pulse_nlp;
        cyc(30);
        pulse_nlp;
        cyc(3);
        led_is(9'h064);
        cyc(80);
        led_is(9'h020);
        @(posedge clk);
        lnk.rx_packet <= 1'b1;
        @(posedge clk);
        lnk.rx_packet <= 1'b0;
        cyc(2);
        led_is(9'h064);
        end_of_test;
    end
endmodule : tb_top
`default_nettype wire

// ### rtl/psi_consts.svh
// Constants of the status indicator and interrupt block
// Summary of operation
// - The receive activity indicator is on while the line receiver is taking in data.
// - The transmit activity indicator is on while the line transmitter is sending data.
// - At 10 Mb/s good link comes from link pulses no more than 16 ms apart or from received packet data.
// - At 100 Mb/s good link drops at once when signal detect falls.
// - At 1000 Mb/s good link needs training done, negotiation complete, a valid link and reliable reception.
// - The duplex indicator is on for full duplex and off for half duplex.
// - The collision indicator is on when transmit and receive are active together in half duplex.
// - The combined activity indicator is on when either transmit or receive is active.
// - Only the speed indicator that matches the current speed is on.
// - Each speed indicator is also gated by good link.
// - A change of link, speed or duplex status raises an interrupt event.
// - The interrupt output is only raised while the enable control bit is set.
// - The interrupt output is driven both high and low, never left floating.
`ifndef PSI_CONSTS_SVH
`define PSI_CONSTS_SVH

`define PSI_CLK_MHZ        100
`define PSI_NLP_GAP_MS     16
`define PSI_NLP_GAP_CYC    (`PSI_NLP_GAP_MS * `PSI_CLK_MHZ * 1000)
`define PSI_SD_QUAL_US     500
`define PSI_SD_QUAL_CYC    (`PSI_SD_QUAL_US * `PSI_CLK_MHZ)

`define PSI_OFF_CTRL       8'h00
`define PSI_OFF_STATUS     8'h04
`define PSI_OFF_MASK       8'h08
`define PSI_OFF_LINK       8'h0c

`define PSI_CTRL_IRQ_EN    0
`define PSI_EV_LINK        0
`define PSI_EV_SPEED       1
`define PSI_EV_DUPLEX      2
`define PSI_EV_W           3

`define PSI_RST_CTRL       1'h0
`define PSI_RST_MASK       3'h7

`endif

// ### rtl/psi_pkg.sv
// Types shared by the status indicator and interrupt block
package psi_pkg;

    typedef enum logic [1:0] {
        PSI_SPEED_10   = 2'h0,
        PSI_SPEED_100  = 2'h1,
        PSI_SPEED_1000 = 2'h2,
        PSI_SPEED_RSVD = 2'h3
    } psi_speed_e;

    typedef enum logic [1:0] {
        PSI_SD_DOWN = 2'h0,
        PSI_SD_QUAL = 2'h1,
        PSI_SD_UP   = 2'h3
    } psi_sd_state_e;

    typedef struct packed {
        logic nlp_pulse;
        logic rx_packet;
        logic signal_detect;
        logic train_done;
        logic an_complete;
        logic gig_link_valid;
        logic remote_rx_ok;
    } psi_link_in_s;

    typedef struct packed {
        logic receive_activity_indicator;
        logic transmit_activity_indicator;
        logic good_link_indicator;
        logic full_duplex_indicator;
        logic collision_indicator;
        logic combined_activity_indicator;
        logic speed_ten_indicator;
        logic speed_hundred_indicator;
        logic speed_gigabit_indicator;
    } psi_led_s;

endpackage : psi_pkg

// ### rtl/psi_top.sv
// Indicator outputs, link qualification and interrupt logic with an AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "psi_consts.svh"

module psi_top #(
    parameter int unsigned P_NLP_GAP_CYC = `PSI_NLP_GAP_CYC,
    parameter int unsigned P_SD_QUAL_CYC = `PSI_SD_QUAL_CYC
) (
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_rst,
    input  wire logic                   i_hsel,
    input  wire logic [31:0]            i_haddr,
    input  wire logic [1:0]             i_htrans,
    input  wire logic                   i_hwrite,
    input  wire logic [2:0]             i_hsize,
    input  wire logic [31:0]            i_hwdata,
    input  wire logic                   i_hready,
    output logic      [31:0]            o_hrdata,
    output logic                        o_hreadyout,
    output logic                        o_hresp,
    input  wire logic                   i_rx_active,
    input  wire logic                   i_tx_active,
    input  wire logic                   i_full_duplex,
    input  wire logic [1:0]             i_speed,
    input  wire psi_pkg::psi_link_in_s  i_link,
    output psi_pkg::psi_led_s           o_led,
    output logic                        o_irq
);

    // Sticky update where a new event wins over a clear in the same cycle
    function automatic logic [`PSI_EV_W-1:0] sticky_next(
        input logic [`PSI_EV_W-1:0] cur,
        input logic [`PSI_EV_W-1:0] set,
        input logic [`PSI_EV_W-1:0] clr
    );
        sticky_next = (cur & ~clr) | set;
    endfunction : sticky_next

    function automatic logic [20:0] cnt_sat(
        input logic [20:0] cnt,
        input logic [20:0] lim
    );
        cnt_sat = (cnt == lim) ? cnt : cnt + 21'h1;
    endfunction : cnt_sat

    localparam logic [20:0] NLP_LIM = 21'(P_NLP_GAP_CYC - 1);
    localparam logic [20:0] SD_LIM  = 21'(P_SD_QUAL_CYC - 1);

    // Bus slave state
    logic                   dp_wr_reg;
    logic [7:0]             dp_addr_reg;
    logic                   ctrl_irq_en_reg;
    logic [`PSI_EV_W-1:0]   status_reg;
    logic [`PSI_EV_W-1:0]   mask_reg;

    // Link qualification state
    logic [20:0]            nlp_cnt_reg;
    logic                   nlp_seen_reg;
    logic                   link10_reg;
    logic [20:0]            sd_cnt_reg;
    psi_pkg::psi_sd_state_e sd_state_reg;
    psi_pkg::psi_sd_state_e sd_state_next;
    logic                   good_link_reg;
    logic [1:0]             speed_reg;
    logic                   duplex_reg;

    // Address phase decode
    wire addr_take   = i_hsel && i_htrans[1] && i_hready;
    wire wr_take     = addr_take && i_hwrite;
    wire rd_take     = addr_take && !i_hwrite;
    wire [7:0] a_off = i_haddr[7:0];
    wire a_hit_ctrl  = (i_haddr[31:8] == 24'h0) && (a_off == `PSI_OFF_CTRL);
    wire a_hit_stat  = (i_haddr[31:8] == 24'h0) && (a_off == `PSI_OFF_STATUS);
    wire a_hit_mask  = (i_haddr[31:8] == 24'h0) && (a_off == `PSI_OFF_MASK);
    wire a_hit_link  = (i_haddr[31:8] == 24'h0) && (a_off == `PSI_OFF_LINK);

    // Data phase write decode
    wire dp_ctrl_wr  = dp_wr_reg && (dp_addr_reg == `PSI_OFF_CTRL);
    wire dp_stat_wr  = dp_wr_reg && (dp_addr_reg == `PSI_OFF_STATUS);
    wire dp_mask_wr  = dp_wr_reg && (dp_addr_reg == `PSI_OFF_MASK);

    // Status word of the link register
    wire [31:0] link_word = {26'h0, i_tx_active, i_rx_active, duplex_reg,
                             speed_reg, good_link_reg};

    wire [31:0] rd_mux =
        a_hit_ctrl ? {31'h0, ctrl_irq_en_reg} :
        a_hit_stat ? {29'h0, status_reg} :
        a_hit_mask ? {29'h0, mask_reg} :
        a_hit_link ? link_word :
        32'h0;

    // Read data is registered at the address phase so it stands through the data phase
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_hrdata <= 32'h0;
        end else if (rd_take) begin
            o_hrdata <= rd_mux;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            dp_wr_reg   <= 1'b0;
            dp_addr_reg <= 8'h0;
        end else if (i_hready) begin
            dp_wr_reg   <= wr_take && (i_haddr[31:8] == 24'h0);
            dp_addr_reg <= a_off;
        end
    end

    // Zero wait states and OKAY only: every access completes in one data phase
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_hreadyout <= 1'b0;
            o_hresp     <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ctrl_irq_en_reg <= `PSI_RST_CTRL;
        end else if (dp_ctrl_wr) begin
            ctrl_irq_en_reg <= i_hwdata[`PSI_CTRL_IRQ_EN];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            mask_reg <= `PSI_RST_MASK;
        end else if (dp_mask_wr) begin
            mask_reg <= i_hwdata[`PSI_EV_W-1:0];
        end
    end

    // 10 Mb/s: a pulse pair inside the gap window, or packet data, brings link up;
    // silence longer than the window takes it down
    wire nlp_expired = (nlp_cnt_reg == NLP_LIM);
    wire nlp_hit     = i_link.nlp_pulse;
    wire pkt_hit     = i_link.rx_packet;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            nlp_cnt_reg  <= 21'h0;
            nlp_seen_reg <= 1'b0;
            link10_reg   <= 1'b0;
        end else if (nlp_hit || pkt_hit) begin
            nlp_cnt_reg  <= 21'h0;
            nlp_seen_reg <= 1'b1;
            if (pkt_hit || (nlp_seen_reg && !nlp_expired)) begin
                link10_reg <= 1'b1;
            end
        end else begin
            nlp_cnt_reg <= cnt_sat(nlp_cnt_reg, NLP_LIM);
            if (nlp_expired) begin
                nlp_seen_reg <= 1'b0;
                link10_reg   <= 1'b0;
            end
        end
    end

    // 100 Mb/s signal detect qualification
    wire sd_done = (sd_cnt_reg == SD_LIM);

    always_comb begin
        sd_state_next = sd_state_reg;
        unique case (sd_state_reg)
            psi_pkg::PSI_SD_DOWN: begin
                if (i_link.signal_detect) begin
                    sd_state_next = psi_pkg::PSI_SD_QUAL;
                end
            end
            psi_pkg::PSI_SD_QUAL: begin
                if (!i_link.signal_detect) begin
                    sd_state_next = psi_pkg::PSI_SD_DOWN;
                end else if (sd_done) begin
                    sd_state_next = psi_pkg::PSI_SD_UP;
                end
            end
            psi_pkg::PSI_SD_UP: begin
                if (!i_link.signal_detect) begin
                    sd_state_next = psi_pkg::PSI_SD_DOWN;
                end
            end
            default: begin
                sd_state_next = psi_pkg::PSI_SD_DOWN;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sd_state_reg <= psi_pkg::PSI_SD_DOWN;
            sd_cnt_reg   <= 21'h0;
        end else begin
            sd_state_reg <= sd_state_next;
            if (sd_state_next == psi_pkg::PSI_SD_QUAL) begin
                sd_cnt_reg <= cnt_sat(sd_cnt_reg, SD_LIM);
            end else begin
                sd_cnt_reg <= 21'h0;
            end
        end
    end

    // Signal detect falling is seen here combinationally so link drops with no extra wait
    wire link100 = (sd_state_reg == psi_pkg::PSI_SD_UP) && i_link.signal_detect;

    wire link1000 = i_link.train_done && i_link.an_complete &&
                    i_link.gig_link_valid && i_link.remote_rx_ok;

    wire link_sel =
        (i_speed == psi_pkg::PSI_SPEED_10)   ? link10_reg :
        (i_speed == psi_pkg::PSI_SPEED_100)  ? link100 :
        (i_speed == psi_pkg::PSI_SPEED_1000) ? link1000 :
        1'b0;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            good_link_reg <= 1'b0;
            speed_reg     <= 2'h0;
            duplex_reg    <= 1'b0;
        end else begin
            good_link_reg <= link_sel;
            speed_reg     <= i_speed;
            duplex_reg    <= i_full_duplex;
        end
    end

    // Status change events, compared against the previous registered view
    wire [`PSI_EV_W-1:0] ev_set;
    assign ev_set[`PSI_EV_LINK]   = (link_sel != good_link_reg);
    assign ev_set[`PSI_EV_SPEED]  = (i_speed != speed_reg);
    assign ev_set[`PSI_EV_DUPLEX] = (i_full_duplex != duplex_reg);

    wire [`PSI_EV_W-1:0] ev_clr = dp_stat_wr ? i_hwdata[`PSI_EV_W-1:0] : {`PSI_EV_W{1'b0}};

    // Events are recorded even while interrupts are disabled, so software can poll them
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            status_reg <= {`PSI_EV_W{1'b0}};
        end else begin
            status_reg <= sticky_next(status_reg, ev_set, ev_clr);
        end
    end

    wire [`PSI_EV_W-1:0] status_new = sticky_next(status_reg, ev_set, ev_clr);
    wire irq_next = ctrl_irq_en_reg && |(status_new & mask_reg);

    // Push-pull output: always driven, high or low
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= irq_next;
        end
    end

    // Indicator outputs
    wire half_duplex = !i_full_duplex;
    wire spd10       = (i_speed == psi_pkg::PSI_SPEED_10);
    wire spd100      = (i_speed == psi_pkg::PSI_SPEED_100);
    wire spd1000     = (i_speed == psi_pkg::PSI_SPEED_1000);

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_led <= '0;
        end else begin
            o_led.receive_activity_indicator  <= i_rx_active;
            o_led.transmit_activity_indicator <= i_tx_active;
            o_led.good_link_indicator         <= link_sel;
            o_led.full_duplex_indicator       <= i_full_duplex;
            o_led.collision_indicator         <= i_tx_active && i_rx_active && half_duplex;
            o_led.combined_activity_indicator <= i_tx_active || i_rx_active;
            o_led.speed_ten_indicator         <= spd10 && link_sel;
            o_led.speed_hundred_indicator     <= spd100 && link_sel;
            o_led.speed_gigabit_indicator     <= spd1000 && link_sel;
        end
    end

endmodule : psi_top
`default_nettype wire
